/* dv/io_ports_host.sv */
// Register bus master standing in for the processor core.
// Assumes an AXI4-Lite slave on aclk; byte address is four times the index.
`timescale 1ns/100ps
module io_ports_host (
	input wire logic aclk,
	output logic [io_ports_pkg::ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [io_ports_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
	end
	// Released payloads are inverted so a stale value cannot be mistaken for a live one
	task automatic wr(input logic [7:0] idx, input logic [11:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {20'h0, d};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~s_axi_wdata;
			end
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) io_ports_tb_top.timeout_hit();
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~s_axi_araddr;
			end
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50) io_ports_tb_top.timeout_hit();
	endtask : rd
endmodule : io_ports_host

/* dv/io_ports_tb_top.sv */
// Self-checking bench for the I/O port unit.
// Assumes the host model drives the register bus; pins and peripherals are driven here.
`timescale 1ns/100ps
module io_ports_tb_top;
	logic aclk, aresetn;
	logic [io_ports_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, pd_in, pf_out, capture_inputs, pwm_e, pwm_f;
	logic [1:0] s_axi_bresp, s_axi_rresp, timer_compare, adc_channel;
	logic [7:0] pa_in, pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe, pe_out, mismatch_sample_strobe;
	logic [11:0] sensed_pin_level, fault;
	logic [15:0] bridge_switch;
	logic pin_irq, irq_mask, spi_enable, sysclk_out_option, sysclk_level, sci_enable;
	logic sci_transmit_out, serial_receive_in, adc_active;
	logic [2:0] spi_out, spi_oe, spi_in;
	int err_count, n_compared;
	// A shorted driver pin reads back the opposite of its commanded level
	assign sensed_pin_level = {pf_out, pe_out} ^ fault;
	io_ports u_io_ports (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pa_in, .pb_in, .pb_out, .pb_oe, .pc_in,
		.pc_out, .pc_oe, .pd_in, .pe_out, .pf_out, .sensed_pin_level, .bridge_switch, .pin_irq,
		.irq_mask, .spi_enable, .spi_out, .spi_oe, .spi_in, .sysclk_out_option, .sysclk_level,
		.timer_compare, .capture_inputs, .sci_enable, .sci_transmit_out, .serial_receive_in,
		.adc_active, .adc_channel, .pwm_e, .pwm_f, .mismatch_sample_strobe);
	io_ports_host u_io_ports_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic timeout_hit();
		err_count++;
		end_of_test();
	endtask : timeout_hit
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask : w
	task automatic wr(input logic [7:0] idx, input logic [11:0] d);
		logic [1:0] r;
		u_io_ports_host.wr(idx, d, r);
		chk({30'h0, r}, {30'h0, io_ports_pkg::RESP_OKAY});
	endtask : wr
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
		input logic [1:0] er = io_ports_pkg::RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		u_io_ports_host.rd(idx, d, r);
		chk(d, exp);
		chk({30'h0, r}, {30'h0, er});
	endtask : rd_chk
	task automatic reset_values();
		chk(pb_oe, 8'h00);
		chk(pc_oe, 8'h00);
		chk(pe_out, 8'h00);
		rd_chk(io_ports_pkg::IDX_PB_DIR, 0);
		rd_chk(io_ports_pkg::IDX_PC_DIR, 0);
		rd_chk(io_ports_pkg::IDX_PC_FN, 0);
		rd_chk(io_ports_pkg::IDX_PE_OUT, 0);
		rd_chk(io_ports_pkg::IDX_PF_OUT, 0);
		rd_chk(io_ports_pkg::IDX_IRQ_PEND, 0);
		rd_chk(8'h20, 0, io_ports_pkg::RESP_SLVERR);
	endtask : reset_values
	task automatic port_a();
		wr(io_ports_pkg::IDX_EDGE_SEL, 8'h03);
		wr(io_ports_pkg::IDX_IRQ_EN, 8'h01);
		wr(io_ports_pkg::IDX_IRQ_PEND, 8'hff);
		pa_in <= 8'h03;
		w(8);
		rd_chk(io_ports_pkg::IDX_IRQ_PEND, 32'h03);
		chk(pin_irq, 1'b1);
		irq_mask <= 1'b1;
		w(4);
		chk(pin_irq, 1'b0);
		irq_mask <= 1'b0;
		wr(io_ports_pkg::IDX_IRQ_PEND, 8'h01);
		rd_chk(io_ports_pkg::IDX_IRQ_PEND, 32'h02);
		w(3);
		chk(pin_irq, 1'b0);
		// Raising bit 2 over a low pin is silent; lowering it again is an event
		wr(io_ports_pkg::IDX_EDGE_SEL, 8'h07);
		wr(io_ports_pkg::IDX_IRQ_PEND, 8'hff);
		wr(io_ports_pkg::IDX_EDGE_SEL, 8'h03);
		w(6);
		rd_chk(io_ports_pkg::IDX_IRQ_PEND, 32'h04);
	endtask : port_a
	task automatic port_b();
		wr(io_ports_pkg::IDX_PB_DIR, 8'h0f);
		wr(io_ports_pkg::IDX_PB_DATA, 8'ha5);
		aresetn <= 1'b0;
		w(2);
		chk(pb_oe, 8'h00);
		aresetn <= 1'b1;
		// Pins held high across reset must not leave a pending flag behind
		rd_chk(io_ports_pkg::IDX_IRQ_PEND, 0);
		rd_chk(io_ports_pkg::IDX_PB_DIR, 0);
		wr(io_ports_pkg::IDX_PB_DIR, 8'hff);
		w(3);
		chk(pb_oe, 8'hff);
		chk(pb_out, 8'ha5);
		spi_enable <= 1'b1;
		spi_out <= 3'b101;
		spi_oe <= 3'b011;
		pb_in <= 8'hc0;
		w(5);
		chk(pb_out[7:5], 3'b001);
		chk(pb_oe[7:5], 3'b011);
		chk(spi_in, 3'b110);
		spi_enable <= 1'b0;
		pb_in <= 8'h00;
		sysclk_out_option <= 1'b1;
		sysclk_level <= 1'b1;
		wr(io_ports_pkg::IDX_PB_DIR, 8'h38);
		w(4);
		chk(pb_oe, 8'h3c);
		chk(pb_out, 8'h24);
		rd_chk(io_ports_pkg::IDX_PB_DIR, 32'h38);
		rd_chk(io_ports_pkg::IDX_PB_DATA, 32'h20);
		sysclk_out_option <= 1'b0;
	endtask : port_b
	task automatic port_c();
		wr(io_ports_pkg::IDX_PC_DIR, 8'hf0);
		wr(io_ports_pkg::IDX_PC_DATA, 8'h00);
		wr(io_ports_pkg::IDX_PC_FN, 8'h01);
		timer_compare <= 2'b10;
		sci_enable <= 1'b1;
		sci_transmit_out <= 1'b1;
		pc_in <= 8'h4a;
		w(5);
		chk(pc_out[5:4], 2'b10);
		chk(pc_oe, 8'hb0);
		chk(capture_inputs, 4'ha);
		chk(pc_out[7], 1'b1);
		chk(serial_receive_in, 1'b1);
		wr(io_ports_pkg::IDX_PC_FN, 8'h00);
		w(3);
		chk(pc_out[5:4], 2'b00);
		wr(io_ports_pkg::IDX_PC_FN, 8'h02);
		w(3);
		chk(pc_out[5:4], 2'b10);
	endtask : port_c
	task automatic port_d();
		pd_in <= 4'hf;
		w(4);
		rd_chk(io_ports_pkg::IDX_PD_IN, 32'h0f);
		adc_active <= 1'b1;
		adc_channel <= 2'd2;
		w(4);
		rd_chk(io_ports_pkg::IDX_PD_IN, 32'h0b);
		adc_active <= 1'b0;
	endtask : port_d
	task automatic drivers();
		wr(io_ports_pkg::IDX_PE_OUT, 8'h3c);
		wr(io_ports_pkg::IDX_PF_OUT, 8'h09);
		w(4);
		chk(pe_out, 8'h3c);
		chk(pf_out, 4'h9);
		wr(io_ports_pkg::IDX_PE_SHORT, 8'hff);
		wr(io_ports_pkg::IDX_PF_SHORT, 8'h0f);
		rd_chk(io_ports_pkg::IDX_PE_SHORT, 0);
		fault <= 12'h801;
		w(8);
		fault <= 12'h000;
		w(4);
		rd_chk(io_ports_pkg::IDX_PE_SHORT, 32'h01);
		rd_chk(io_ports_pkg::IDX_PF_SHORT, 32'h08);
		wr(io_ports_pkg::IDX_PE_SHORT, 8'h00);
		rd_chk(io_ports_pkg::IDX_PE_SHORT, 32'h01);
		wr(io_ports_pkg::IDX_PE_SHORT, 8'h01);
		wr(io_ports_pkg::IDX_PF_SHORT, 8'h08);
		rd_chk(io_ports_pkg::IDX_PE_SHORT, 0);
		rd_chk(io_ports_pkg::IDX_PF_SHORT, 0);
	endtask : drivers
	task automatic bridges();
		// Pair 0 and port F line 0 follow their pulse inputs
		wr(io_ports_pkg::IDX_PULSE_SEL, 12'h103);
		pwm_e <= 4'h1;
		w(3);
		chk(pe_out, 8'h3f);
		chk(pf_out, 4'h8);
		chk(bridge_switch[3:0], 4'h9);
		pwm_e <= 4'h0;
		w(3);
		chk(pe_out, 8'h3e);
		chk(bridge_switch[3:0], 4'ha);
		wr(io_ports_pkg::IDX_BRIDGE_DIR, 8'h01);
		w(3);
		chk(pe_out, 8'h3d);
		pwm_e <= 4'h1;
		w(3);
		chk(pe_out, 8'h3f);
		chk(bridge_switch[3:0], 4'h6);
		// A pulse-mode short is only latched at its channel strobe
		pwm_e <= 4'h0;
		fault <= 12'h001;
		w(8);
		rd_chk(io_ports_pkg::IDX_PE_SHORT, 0);
		mismatch_sample_strobe <= 8'h01;
		w(1);
		mismatch_sample_strobe <= 8'h00;
		w(6);
		rd_chk(io_ports_pkg::IDX_PE_SHORT, 32'h01);
		fault <= 12'h000;
		wr(io_ports_pkg::IDX_PE_SHORT, 8'h01);
		rd_chk(io_ports_pkg::IDX_PE_SHORT, 0);
	endtask : bridges
	initial begin
		err_count = 0;
		n_compared = 0;
		aresetn = 1'b0;
		{pa_in, pb_in, pc_in, pd_in, fault, irq_mask, spi_enable, spi_out, spi_oe} = '0;
		{sysclk_out_option, sysclk_level, timer_compare, sci_enable, sci_transmit_out} = '0;
		{adc_active, adc_channel, pwm_e, pwm_f, mismatch_sample_strobe} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		reset_values();
		port_a();
		port_b();
		port_c();
		port_d();
		drivers();
		bridges();
		end_of_test();
	end
endmodule : io_ports_tb_top

/* hdl/io_ports.sv */
// I/O port unit: ports A-F, pin sharing, power-driver short detect, bridges.
// Assumes an AXI4-Lite master on aclk and peripheral signals on aclk.
`timescale 1ns/100ps
module io_ports (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [io_ports_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [io_ports_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] pa_in,
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	input wire logic [7:0] pc_in,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe,
	input wire logic [3:0] pd_in,
	output logic [7:0] pe_out,
	output logic [3:0] pf_out,
	input wire logic [11:0] sensed_pin_level,
	output logic [15:0] bridge_switch,
	output logic pin_irq,
	input wire logic irq_mask,
	input wire logic spi_enable,
	input wire logic [2:0] spi_out,
	input wire logic [2:0] spi_oe,
	output logic [2:0] spi_in,
	input wire logic sysclk_out_option,
	input wire logic sysclk_level,
	input wire logic [1:0] timer_compare,
	output logic [3:0] capture_inputs,
	input wire logic sci_enable,
	input wire logic sci_transmit_out,
	output logic serial_receive_in,
	input wire logic adc_active,
	input wire logic [1:0] adc_channel,
	input wire logic [3:0] pwm_e,
	input wire logic [3:0] pwm_f,
	input wire logic [7:0] mismatch_sample_strobe
);
	typedef struct packed {
		logic [7:0] pa_s1, pa_s2, pa_x;
		logic [7:0] pb_s1, pb_s2, pc_s1, pc_s2;
		logic [3:0] pd_s1, pd_s2;
		logic [11:0] se_s1, se_s2, cmd1, cmd2;
		logic [7:0] stb1, stb2;
		logic [7:0] pb_dat, pb_dir, pc_dat, pc_dir, pc_fn;
		logic [7:0] pe_dat;
		logic [3:0] pf_dat;
		logic [7:0] edge_sel, irq_en, irq_pend;
		logic [11:0] pulse_sel, short_flags;
		logic [3:0] br_dir, wd_hi;
		logic [7:0] pb_o, pb_e, pc_o, pc_e, pe_o;
		logic [3:0] pf_o;
		logic [15:0] bsw;
		logic irq;
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
		logic haw, hw;
		logic [7:0] awi, wd;
		logic wlane, wlane_hi;
	} state_t;

	state_t s_q, s_d;
	logic [7:0] br_lvl;
	logic [15:0] br_sw;
	logic [11:0] stb_pin;

	// Bridge pairs: left pin 2p, right pin 2p+1
	for (genvar p = 0; p < 4; p++) begin : g_bridge
		always_comb begin
			br_lvl[2*p] = s_q.br_dir[p] ? 1'b1 : pwm_e[p];
			br_lvl[2*p+1] = s_q.br_dir[p] ? pwm_e[p] : 1'b1;
			if (!pwm_e[p])
				br_sw[4*p+:4] = io_ports_pkg::SW_OFF;
			else if (s_q.br_dir[p])
				br_sw[4*p+:4] = io_ports_pkg::SW_BWD;
			else
				br_sw[4*p+:4] = io_ports_pkg::SW_FWD;
			stb_pin[2*p] = s_q.stb2[p];
			stb_pin[2*p+1] = s_q.stb2[p];
			stb_pin[8+p] = s_q.stb2[4+p];
		end
	end

	always_comb begin
		logic [7:0] x, ev, rd8, ri;
		logic [11:0] mis, sh_set, sh_clr;
		logic ok, aw_go, ar_go;
		s_d = s_q;
		x = '0;
		ev = '0;
		rd8 = '0;
		ri = '0;
		mis = '0;
		sh_set = '0;
		sh_clr = '0;
		ok = 1'b0;
		aw_go = 1'b0;
		ar_go = 1'b0;
		// Two-stage synchronisers for all pin-side inputs
		s_d.pa_s1 = pa_in;
		s_d.pa_s2 = s_q.pa_s1;
		s_d.pb_s1 = pb_in;
		s_d.pb_s2 = s_q.pb_s1;
		s_d.pc_s1 = pc_in;
		s_d.pc_s2 = s_q.pc_s1;
		s_d.pd_s1 = pd_in;
		s_d.pd_s2 = s_q.pd_s1;
		s_d.se_s1 = sensed_pin_level;
		s_d.se_s2 = s_q.se_s1;
		// Commanded level and strobe delayed to line up with the sensed level
		s_d.cmd1 = {s_q.pf_o, s_q.pe_o};
		s_d.cmd2 = s_q.cmd1;
		s_d.stb1 = mismatch_sample_strobe;
		s_d.stb2 = s_q.stb1;

		// Folding the edge select into the level makes a select change look like an edge
		x = s_q.pa_s2 ~^ s_q.edge_sel;
		s_d.pa_x = x;
		ev = x & ~s_q.pa_x;

		// Pulse-mode pins compare only at their strobe, data pins every clock
		mis = s_q.cmd2 ^ s_q.se_s2;
		sh_set = mis & (~s_q.pulse_sel | stb_pin);

		// AXI write: address and data taken in either order
		aw_go = s_axi_awvalid & s_q.awready;
		if (aw_go) begin
			s_d.haw = 1'b1;
			s_d.awi = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid & s_q.wready) begin
			s_d.hw = 1'b1;
			s_d.wd = s_axi_wdata[7:0];
			s_d.wlane = s_axi_wstrb[0];
			s_d.wd_hi = s_axi_wdata[11:8];
			s_d.wlane_hi = s_axi_wstrb[1];
		end
		if (s_q.bvalid & s_axi_bready)
			s_d.bvalid = 1'b0;
		if (s_q.haw & s_q.hw & !s_q.bvalid) begin
			ok = 1'b1;
			if (s_q.awi == io_ports_pkg::IDX_PB_DATA) begin
				if (s_q.wlane)
					s_d.pb_dat = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_PC_DATA) begin
				if (s_q.wlane)
					s_d.pc_dat = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_PD_IN) begin
				ok = 1'b1;
			end else if (s_q.awi == io_ports_pkg::IDX_PB_DIR) begin
				if (s_q.wlane)
					s_d.pb_dir = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_PC_DIR) begin
				if (s_q.wlane)
					s_d.pc_dir = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_PC_FN) begin
				if (s_q.wlane)
					s_d.pc_fn = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_EDGE_SEL) begin
				if (s_q.wlane)
					s_d.edge_sel = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_IRQ_EN) begin
				if (s_q.wlane)
					s_d.irq_en = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_IRQ_PEND) begin
				if (s_q.wlane)
					ri = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_PULSE_SEL) begin
				if (s_q.wlane)
					s_d.pulse_sel[7:0] = s_q.wd;
				if (s_q.wlane_hi)
					s_d.pulse_sel[11:8] = s_q.wd_hi;
			end else if (s_q.awi == io_ports_pkg::IDX_BRIDGE_DIR) begin
				if (s_q.wlane)
					s_d.br_dir = s_q.wd[3:0];
			end else if (s_q.awi == io_ports_pkg::IDX_PE_OUT) begin
				if (s_q.wlane)
					s_d.pe_dat = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_PF_OUT) begin
				if (s_q.wlane)
					s_d.pf_dat = s_q.wd[3:0];
			end else if (s_q.awi == io_ports_pkg::IDX_PE_SHORT) begin
				if (s_q.wlane)
					sh_clr[7:0] = s_q.wd;
			end else if (s_q.awi == io_ports_pkg::IDX_PF_SHORT) begin
				if (s_q.wlane)
					sh_clr[11:8] = s_q.wd[3:0];
			end else begin
				ok = 1'b0;
			end
			s_d.bvalid = 1'b1;
			s_d.bresp = ok ? io_ports_pkg::RESP_OKAY : io_ports_pkg::RESP_SLVERR;
			s_d.haw = 1'b0;
			s_d.hw = 1'b0;
		end
		s_d.awready = !s_d.haw & !s_d.bvalid;
		s_d.wready = !s_d.hw & !s_d.bvalid;

		// Set wins over a clear in the same cycle
		s_d.irq_pend = (s_q.irq_pend & ~ri) | ev;
		s_d.short_flags = (s_q.short_flags & ~sh_clr) | sh_set;
		if (sysclk_out_option)
			s_d.pb_dat[io_ports_pkg::SYSCLK_PIN] = 1'b0;

		// AXI read
		ar_go = s_axi_arvalid & s_q.arready;
		if (s_q.rvalid & s_axi_rready) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end
		if (ar_go) begin
			ok = 1'b1;
			if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PB_DATA) begin
				// Output pins read the latch, input pins read the pin
				rd8 = (s_q.pb_dat & s_q.pb_dir) | (s_q.pb_s2 & ~s_q.pb_dir);
				if (sysclk_out_option)
					rd8[io_ports_pkg::SYSCLK_PIN] = 1'b0;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PC_DATA) begin
				rd8 = (s_q.pc_dat & s_q.pc_dir) | (s_q.pc_s2 & ~s_q.pc_dir);
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PD_IN) begin
				rd8[3:0] = s_q.pd_s2;
				if (adc_active)
					rd8[adc_channel] = 1'b0;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PB_DIR) begin
				rd8 = s_q.pb_dir;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PC_DIR) begin
				rd8 = s_q.pc_dir;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PC_FN) begin
				rd8 = s_q.pc_fn;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_EDGE_SEL) begin
				rd8 = s_q.edge_sel;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_IRQ_EN) begin
				rd8 = s_q.irq_en;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_IRQ_PEND) begin
				rd8 = s_q.irq_pend;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PULSE_SEL) begin
				rd8 = s_q.pulse_sel[7:0];
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_BRIDGE_DIR) begin
				rd8[3:0] = s_q.br_dir;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PE_OUT) begin
				rd8 = s_q.pe_dat;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PF_OUT) begin
				rd8[3:0] = s_q.pf_dat;
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PE_SHORT) begin
				rd8 = s_q.short_flags[7:0];
			end else if (s_axi_araddr[9:2] == io_ports_pkg::IDX_PF_SHORT) begin
				rd8[3:0] = s_q.short_flags[11:8];
			end else begin
				ok = 1'b0;
			end
			s_d.rdata = {24'h000000, rd8};
			s_d.rresp = ok ? io_ports_pkg::RESP_OKAY : io_ports_pkg::RESP_SLVERR;
			s_d.rvalid = 1'b1;
			s_d.arready = 1'b0;
		end

		// Port B pins
		s_d.pb_e = s_q.pb_dir;
		s_d.pb_o = s_q.pb_dat & s_q.pb_dir;
		if (sysclk_out_option) begin
			s_d.pb_e[io_ports_pkg::SYSCLK_PIN] = 1'b1;
			s_d.pb_o[io_ports_pkg::SYSCLK_PIN] = sysclk_level;
		end
		if (spi_enable) begin
			s_d.pb_e[io_ports_pkg::SPI_LO+:3] = spi_oe;
			s_d.pb_o[io_ports_pkg::SPI_LO+:3] = spi_out & spi_oe;
		end
		// Port C pins
		s_d.pc_e = s_q.pc_dir;
		s_d.pc_o = s_q.pc_dat & s_q.pc_dir;
		if (s_q.pc_fn[io_ports_pkg::CMP_SEL_A] | s_q.pc_fn[io_ports_pkg::CMP_SEL_B]) begin
			s_d.pc_e[io_ports_pkg::CMP_HI] = 1'b1;
			s_d.pc_e[io_ports_pkg::CMP_LO] = 1'b1;
			s_d.pc_o[io_ports_pkg::CMP_HI] = timer_compare[1];
			s_d.pc_o[io_ports_pkg::CMP_LO] = timer_compare[0];
		end
		if (sci_enable) begin
			s_d.pc_e[io_ports_pkg::SCI_RX] = 1'b0;
			s_d.pc_o[io_ports_pkg::SCI_RX] = 1'b0;
			s_d.pc_e[io_ports_pkg::SCI_TX] = 1'b1;
			s_d.pc_o[io_ports_pkg::SCI_TX] = sci_transmit_out;
		end
		// Power drivers
		s_d.pe_o = (s_q.pe_dat & ~s_q.pulse_sel[7:0]) | (br_lvl & s_q.pulse_sel[7:0]);
		s_d.pf_o = (s_q.pf_dat & ~s_q.pulse_sel[11:8]) | (pwm_f & s_q.pulse_sel[11:8]);
		s_d.bsw = br_sw;
		s_d.irq = (|(s_q.irq_pend & s_q.irq_en)) & !irq_mask;

		if (!aresetn) begin
			s_d = '0;
			// Port B and C data latches survive reset
			s_d.pb_dat = s_q.pb_dat;
			s_d.pc_dat = s_q.pc_dat;
			s_d.pa_x = '1; // Matches the post-reset level, so release shows no false edge
			s_d.awready = 1'b1;
			s_d.wready = 1'b1;
			s_d.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		s_q <= s_d;
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = s_q.rdata;
	assign pb_out = s_q.pb_o;
	assign pb_oe = s_q.pb_e;
	assign pc_out = s_q.pc_o;
	assign pc_oe = s_q.pc_e;
	assign pe_out = s_q.pe_o;
	assign pf_out = s_q.pf_o;
	assign bridge_switch = s_q.bsw;
	assign pin_irq = s_q.irq;
	assign spi_in = s_q.pb_s2[io_ports_pkg::SPI_LO+:3];
	assign capture_inputs = s_q.pc_s2[3:0];
	assign serial_receive_in = s_q.pc_s2[io_ports_pkg::SCI_RX];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_irq_gate: assert property ($rose(s_q.irq) |-> $past(!irq_mask))
		else $error("irq rose while masked");
	chk_irq_enable: assert property ((s_q.irq_pend & s_q.irq_en) == 8'h00 |=> !s_q.irq)
		else $error("irq without enabled flag");
	chk_pend_set: assert property (!s_q.pa_x[0] && (s_q.pa_s2[0] ~^ s_q.edge_sel[0])
		|=> s_q.irq_pend[0]) else $error("pending flag not set");
	property ev_hold;
		(s_q.irq_pend[0] && !(s_q.haw && s_q.hw && s_q.awi == io_ports_pkg::IDX_IRQ_PEND))
			|=> s_q.irq_pend[0];
	endproperty
	chk_pend_hold: assert property (ev_hold)
		else $error("pending flag lost");
	chk_short_hold: assert property ((s_q.short_flags[0] && !(s_q.haw && s_q.hw &&
		s_q.awi == io_ports_pkg::IDX_PE_SHORT)) |=> s_q.short_flags[0])
		else $error("short flag dropped");
	chk_short_set: assert property ((s_q.cmd2[0] != s_q.se_s2[0]) && !s_q.pulse_sel[0]
		|=> s_q.short_flags[0])
		else $error("static mismatch not latched");
	chk_sysclk_pin: assert property (sysclk_out_option |=> s_q.pb_e[2] && s_q.pb_o[2] ==
		$past(sysclk_level))
		else $error("system clock not on pin");
	chk_bit2_lock: assert property (sysclk_out_option |=> !s_q.pb_dat[2])
		else $error("data bit 2 kept");
	chk_bridge_code: assert property (pwm_e[0] && !s_q.br_dir[0] |=> s_q.bsw[3:0] ==
		io_ports_pkg::SW_FWD)
		else $error("forward code wrong");
	chk_bresp_time: assert property (s_q.haw && s_q.hw && !s_q.bvalid |=> s_q.bvalid)
		else $error("write answer late");
	cov_irq: cover property ($rose(s_q.irq));
	cov_short: cover property ($rose(s_q.short_flags[0]));
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : io_ports

/* hdl/io_ports_pkg.sv */
// Register indices, field positions and bus answers for the I/O port unit.
// Assumes a 32-bit AXI4-Lite master; byte address is four times the index.
package io_ports_pkg;
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_PB_DATA = 8'h01;
	localparam logic [7:0] IDX_PC_DATA = 8'h02;
	localparam logic [7:0] IDX_PD_IN = 8'h03;
	localparam logic [7:0] IDX_PB_DIR = 8'h05;
	localparam logic [7:0] IDX_PC_DIR = 8'h06;
	localparam logic [7:0] IDX_PC_FN = 8'h07;
	localparam logic [7:0] IDX_EDGE_SEL = 8'h08;
	localparam logic [7:0] IDX_IRQ_EN = 8'h09;
	localparam logic [7:0] IDX_IRQ_PEND = 8'h0a;
	localparam logic [7:0] IDX_PULSE_SEL = 8'h0b;
	localparam logic [7:0] IDX_BRIDGE_DIR = 8'h0c;
	localparam logic [7:0] IDX_PE_OUT = 8'h40;
	localparam logic [7:0] IDX_PE_SHORT = 8'h41;
	localparam logic [7:0] IDX_PF_OUT = 8'h42;
	localparam logic [7:0] IDX_PF_SHORT = 8'h43;
	localparam int CMP_SEL_A = 0;
	localparam int CMP_SEL_B = 1;
	localparam int SYSCLK_PIN = 2;
	localparam int SPI_LO = 5;
	localparam int SCI_RX = 6;
	localparam int SCI_TX = 7;
	localparam int CMP_LO = 4;
	localparam int CMP_HI = 5;
	localparam logic [3:0] SW_FWD = 4'h9;
	localparam logic [3:0] SW_BWD = 4'h6;
	localparam logic [3:0] SW_OFF = 4'ha;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : io_ports_pkg
